// ---- core/adcctl_consts.vh ----
`ifndef ADCCTL_CONSTS_VH
`define ADCCTL_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define ADCCTL_OFS_START_STATUS 8'h00
`define ADCCTL_OFS_SRC_CLOCK 8'h04
`define ADCCTL_OFS_REFERENCE 8'h08
`define ADCCTL_OFS_PIN_ANALOG 8'h0c
`define ADCCTL_OFS_RESULT 8'h10
`define ADCCTL_OFS_IRQ_STATUS 8'h14
`define ADCCTL_OFS_IRQ_MASK 8'h18

// ****************************************
// Start/status/channel register fields
// ****************************************
`define ADCCTL_START_BIT 7
`define ADCCTL_BUSY_BIT 6
`define ADCCTL_ENABLE_BIT 5
`define ADCCTL_ALIGN_BIT 4
`define ADCCTL_CHAN_LSB 0
`define ADCCTL_CHAN_MSB 2

// ****************************************
// Source/clock register fields
// ****************************************
`define ADCCTL_SRC_LSB 5
`define ADCCTL_SRC_MSB 7
`define ADCCTL_CLKDIV_LSB 0
`define ADCCTL_CLKDIV_MSB 2

// ****************************************
// Reference register fields
// ****************************************
`define ADCCTL_REFAMP_BIT 7
`define ADCCTL_BANDGAP_BIT 6
`define ADCCTL_EXTREF_BIT 5
`define ADCCTL_REFOUT_BIT 4
`define ADCCTL_REFSEL_LSB 0
`define ADCCTL_REFSEL_MSB 3

// ****************************************
// Codes
// ****************************************
`define ADCCTL_SRC_EXT_A 3'h0
`define ADCCTL_SRC_EXT_B 3'h4
`define ADCCTL_REF_SUPPLY 4'h0
`define ADCCTL_REF_EXT_LO 4'h1
`define ADCCTL_REF_EXT_HI 4'h4
`define ADCCTL_REF_BG_LO 4'ha
`define ADCCTL_REF_BG_HI 4'hc

// ****************************************
// Reset values and interrupt done bit
// ****************************************
`define ADCCTL_RST_BYTE 8'h00
`define ADCCTL_RST_PIN_ANALOG 8'hff
`define ADCCTL_RST_RESULT 12'h000
`define ADCCTL_IRQ_DONE_BIT 0

`endif

// ---- core/adcctl_clkdiv.v ----
`timescale 1ns/10ps
`include "adcctl_consts.vh"

module adcctl_clkdiv (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Control
  input wire run,
  input wire [2:0] divSel,
  // Converter clock enable
  output reg convClkTick
);

  // ****************************************
  // Divide by two to the power of the code
  // ****************************************
  function [6:0] divLast;
    input [2:0] code;
    begin
      divLast = (7'h01 << code) - 7'h01;
    end
  endfunction

  reg [6:0] count;

  // Tick once per converter period; code 0 ticks every cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 7'h00;
      convClkTick <= 1'b0;
    end else if (!run) begin
      count <= 7'h00;
      convClkTick <= 1'b0;
    end else if (count >= divLast(divSel)) begin
      count <= 7'h00;
      convClkTick <= 1'b1;
    end else begin
      count <= count + 7'h01;
      convClkTick <= 1'b0;
    end
  end

endmodule // adcctl_clkdiv

// ---- core/adcctl_top.v ----
`timescale 1ns/10ps
`include "adcctl_consts.vh"

// What this block does
// - Source 000/100 routes chosen external channel
// - Other sources pick supply or reference scaled
// - Internal source disconnects the external channel
// - Converter clock is system clock over 2^code
// - Unused source/clock register bits read zero
// - Amplifier enable provides internal reference voltage
// - Bandgap enable powers the bandgap circuit
// - Bandgap off unless bandgap enable bit, LOW_VOLTAGE_DETECT or LOW_VOLTAGE_RESET
// - External reference control connects reference pin
// - Output control drives reference onto pin
// - Reference code picks supply, external or bandgap
// - Bandgap reference cuts supply and pin paths
// - Start low-high-low converts; high holds reset
// - Busy set when start returns low, cleared with interrupt
// - Alignment bit places result left or right
// - Mask bit makes pin analog, drops digital
module adcctl_top (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Interrupt
  output wire irq,
  // Converter core
  output wire convPowerDown,
  output wire convReset,
  output reg convStart,
  output wire convClkTick,
  input wire convDone,
  input wire [11:0] convData,
  // Input multiplexer
  output wire extChannelConnect,
  output wire [2:0] extChannelSel,
  output wire srcSupply,
  output wire srcIntRef,
  output wire [1:0] srcScale,
  // Reference network
  output wire refAmpOn,
  output wire bandgapOn,
  output wire refFromSupply,
  output wire refFromExtPin,
  output wire refFromBandgap,
  output wire [2:0] refMultiplier,
  output wire extRefPinConnect,
  output wire refOutputEnable,
  input wire lowVoltageDetectEn,
  input wire lowVoltageResetEn,
  // Pins
  input wire [7:0] pinPullHighAllow,
  output wire [7:0] pinAnalogMask,
  output wire [7:0] pinDigitalEn,
  output wire [7:0] pinPullHighEn
);

  // ****************************************
  // Reset release
  // ****************************************
  reg rstMeta;
  reg rstn;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'b0;
      rstn <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstn <= rstMeta;
    end
  end

  // ****************************************
  // Functions
  // ****************************************
  function isExtSource;
    input [2:0] src;
    begin
      isExtSource = (src == `ADCCTL_SRC_EXT_A) ||
                    (src == `ADCCTL_SRC_EXT_B);
    end
  endfunction

  function inRange;
    input [3:0] code;
    input [3:0] lo;
    input [3:0] hi;
    begin
      inRange = (code >= lo) && (code <= hi);
    end
  endfunction

  // ****************************************
  // Register storage
  // ****************************************
  reg startBit;
  reg convEnable;
  reg alignRight;
  reg [2:0] chanSel;
  reg [2:0] srcSel;
  reg [2:0] clkDivSel;
  reg [7:0] refCtrl;
  reg [7:0] pinMask;
  reg [11:0] result;
  reg irqStatus;
  reg irqMask;

  wire wrEn;
  wire rdAccess;
  wire mapped;

  assign wrEn = psel && penable && pwrite;
  assign rdAccess = psel && penable && !pwrite;
  assign mapped = (paddr == `ADCCTL_OFS_START_STATUS) ||
                  (paddr == `ADCCTL_OFS_SRC_CLOCK) ||
                  (paddr == `ADCCTL_OFS_REFERENCE) ||
                  (paddr == `ADCCTL_OFS_PIN_ANALOG) ||
                  (paddr == `ADCCTL_OFS_RESULT) ||
                  (paddr == `ADCCTL_OFS_IRQ_STATUS) ||
                  (paddr == `ADCCTL_OFS_IRQ_MASK);

  // Zero wait states; unmapped offsets answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      startBit <= 1'b0;
      convEnable <= 1'b0;
      alignRight <= 1'b0;
      chanSel <= 3'h0;
      srcSel <= 3'h0;
      clkDivSel <= 3'h0;
      refCtrl <= `ADCCTL_RST_BYTE;
      pinMask <= `ADCCTL_RST_PIN_ANALOG;
      irqMask <= 1'b0;
    end else if (wrEn) begin
      case (paddr)
        `ADCCTL_OFS_START_STATUS: begin
          startBit <= pwdata[`ADCCTL_START_BIT];
          convEnable <= pwdata[`ADCCTL_ENABLE_BIT];
          alignRight <= pwdata[`ADCCTL_ALIGN_BIT];
          chanSel <= pwdata[`ADCCTL_CHAN_MSB:`ADCCTL_CHAN_LSB];
        end
        `ADCCTL_OFS_SRC_CLOCK: begin
          srcSel <= pwdata[`ADCCTL_SRC_MSB:`ADCCTL_SRC_LSB];
          clkDivSel <= pwdata[`ADCCTL_CLKDIV_MSB:`ADCCTL_CLKDIV_LSB];
        end
        `ADCCTL_OFS_REFERENCE: begin
          refCtrl <= pwdata[7:0];
        end
        `ADCCTL_OFS_PIN_ANALOG: begin
          pinMask <= pwdata[7:0];
        end
        `ADCCTL_OFS_IRQ_MASK: begin
          irqMask <= pwdata[`ADCCTL_IRQ_DONE_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_ARMED = 3'h2;
  localparam [2:0] ST_CONV = 3'h4;

  reg [2:0] state;
  reg [2:0] next_state;
  reg busy;
  wire doneEvent;

  // Completion only counts while a conversion is in flight
  assign doneEvent = convEnable && (state == ST_CONV) && convDone &&
                     !startBit;

  always @* begin
    next_state = state;
    if (!convEnable) begin
      next_state = ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (startBit) begin
            next_state = ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (!startBit) begin
            next_state = ST_CONV;
          end
        end
        ST_CONV: begin
          // A fresh rising start aborts and holds reset
          if (startBit) begin
            next_state = ST_ARMED;
          end else if (convDone) begin
            next_state = ST_IDLE;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      convStart <= 1'b0;
      result <= `ADCCTL_RST_RESULT;
    end else begin
      state <= next_state;
      convStart <= (state == ST_ARMED) && (next_state == ST_CONV);
      if (next_state == ST_CONV) begin
        busy <= 1'b1;
      end else begin
        busy <= 1'b0;
      end
      // Result only moves on a real completion, so it holds while off
      if (doneEvent) begin
        result <= convData;
      end
    end
  end

  // Converter held in reset while start stays high or disabled
  assign convReset = (state == ST_ARMED) || !convEnable;
  assign convPowerDown = !convEnable;

  adcctl_clkdiv u_clkdiv (
    .clk(clk),
    .rstn(rstn),
    .run(convEnable),
    .divSel(clkDivSel),
    .convClkTick(convClkTick)
  );

  // ****************************************
  // Interrupt
  // ****************************************
  wire irqClear;

  assign irqClear = wrEn && (paddr == `ADCCTL_OFS_IRQ_STATUS) &&
                    pwdata[`ADCCTL_IRQ_DONE_BIT];

  // Set beats clear so a completion in the clearing cycle is kept
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqStatus <= 1'b0;
    end else if (doneEvent) begin
      irqStatus <= 1'b1;
    end else if (irqClear) begin
      irqStatus <= 1'b0;
    end
  end

  assign irq = irqStatus && irqMask;

  // ****************************************
  // Input multiplexer
  // ****************************************
  wire extSel;

  assign extSel = isExtSource(srcSel);
  assign extChannelConnect = convEnable && extSel;
  assign extChannelSel = chanSel;
  assign srcSupply = convEnable && !extSel && !srcSel[2];
  assign srcIntRef = convEnable && !extSel && srcSel[2];
  // 0 means divide by 1, 1 by 2, 2 by 4
  assign srcScale = extSel ? 2'h0 : srcSel[1:0] - 2'h1;

  // ****************************************
  // Reference network
  // ****************************************
  wire [3:0] refSel;
  wire refBg;
  wire refExt;

  assign refSel = refCtrl[`ADCCTL_REFSEL_MSB:`ADCCTL_REFSEL_LSB];
  assign refExt = inRange(refSel, `ADCCTL_REF_EXT_LO,
                          `ADCCTL_REF_EXT_HI);
  assign refBg = inRange(refSel, `ADCCTL_REF_BG_LO,
                         `ADCCTL_REF_BG_HI);
  // Reserved code 1001 falls back to the supply like the others
  assign refFromSupply = !refExt && !refBg;
  assign refFromExtPin = refExt;
  assign refFromBandgap = refBg;
  assign refMultiplier = (refExt || refBg) ? refSel[2:0] :
                         3'h1;
  assign extRefPinConnect = refCtrl[`ADCCTL_EXTREF_BIT] &&
                            !refBg;
  assign refOutputEnable = refCtrl[`ADCCTL_REFOUT_BIT];
  // Amplifier stays under software control to save power
  assign refAmpOn = refCtrl[`ADCCTL_REFAMP_BIT];
  assign bandgapOn = refCtrl[`ADCCTL_BANDGAP_BIT] ||
                     lowVoltageDetectEn ||
                     lowVoltageResetEn;

  // ****************************************
  // Pin function
  // ****************************************
  assign pinAnalogMask = pinMask;
  assign pinDigitalEn = ~pinMask;
  assign pinPullHighEn = pinPullHighAllow & ~pinMask;

  // ****************************************
  // Read data
  // ****************************************
  reg [31:0] rdata;
  wire [15:0] aligned;

  assign aligned = alignRight ? {4'h0, result} :
                   {result, 4'h0};

  always @* begin
    rdata = 32'h00000000;
    if (rdAccess) begin
      case (paddr)
        `ADCCTL_OFS_START_STATUS: begin
          rdata[7:0] = {startBit, busy, convEnable, alignRight,
                        1'b0, chanSel};
        end
        `ADCCTL_OFS_SRC_CLOCK: begin
          rdata[7:0] = {srcSel, 2'h0, clkDivSel};
        end
        `ADCCTL_OFS_REFERENCE: begin
          rdata[7:0] = refCtrl;
        end
        `ADCCTL_OFS_PIN_ANALOG: begin
          rdata[7:0] = pinMask;
        end
        `ADCCTL_OFS_RESULT: begin
          rdata[15:0] = aligned;
        end
        `ADCCTL_OFS_IRQ_STATUS: begin
          rdata[0] = irqStatus;
        end
        `ADCCTL_OFS_IRQ_MASK: begin
          rdata[0] = irqMask;
        end
        default: begin
          rdata = 32'h00000000;
        end
      endcase
    end
  end

  assign prdata = rdata;

endmodule // adcctl_top

// ---- verification/adcctl_top_properties.sv ----
`timescale 1ns/10ps
// ****************
// Port checker
// ****************
module adcctl_top_props (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Converter and routing
  input wire convPowerDown, convReset, convStart, convClkTick,
  input wire extChannelConnect, srcSupply, srcIntRef,
  input wire refFromSupply, refFromExtPin, refFromBandgap,
  input wire extRefPinConnect, bandgapOn,
  input wire lowVoltageDetectEn, lowVoltageResetEn,
  // Pins
  input wire [7:0] pinPullHighAllow, pinAnalogMask,
  input wire [7:0] pinDigitalEn, pinPullHighEn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_ext_switched_off: assert property (
    (srcSupply || srcIntRef) |-> !extChannelConnect)
    else $error("external channel left connected");
  chk_src_single: assert property (!(srcSupply && srcIntRef))
    else $error("two internal sources at once");
  chk_bg_paths_cut: assert property (refFromBandgap |->
    !refFromSupply && !refFromExtPin && !extRefPinConnect)
    else $error("supply or pin path kept with bandgap");
  chk_bg_power_kept: assert property (
    (lowVoltageDetectEn || lowVoltageResetEn) |-> bandgapOn)
    else $error("bandgap off while detector needs it");
  chk_pin_digital_off: assert property (
    pinDigitalEn == ~pinAnalogMask &&
    pinPullHighEn == (pinPullHighAllow & ~pinAnalogMask))
    else $error("pin function not removed");
  chk_start_one_cycle: assert property (convStart |=> !convStart)
    else $error("start pulse too long");
  chk_off_quiet: assert property (convPowerDown |->
    convReset ##1 (!convStart && !convClkTick))
    else $error("converter active while disabled");
  chk_reset_no_start: assert property (convReset |-> !convStart)
    else $error("start while converter held");
  cover property (convStart);
  cover property (refFromBandgap);
  cover property (srcIntRef);
endmodule // adcctl_top_props

bind adcctl_top adcctl_top_props chk_u (.*);

// ---- verification/adcctl_core_model.sv ----
`timescale 1ns/10ps
// ****************
// Converter core
// ****************
module adcctl_core_model #(parameter int TICKS = 14) (
  input wire clk,
  input wire convReset,
  input wire convStart,
  input wire convClkTick,
  input wire [11:0] resultValue,
  output logic convDone = 0,
  output logic [11:0] convData = 0
);
  int cnt = 0;
  logic busy = 0;
  always @(posedge clk) begin
    convDone <= 0;
    // Data toggles outside completion so a stale sample shows
    convData <= ~convData;
    if (convReset) begin
      busy <= 0;
    end else if (convStart) begin
      busy <= 1;
      cnt <= 0;
    end else if (busy && convClkTick) begin
      cnt <= cnt + 1;
      if (cnt == TICKS - 1) begin
        convDone <= 1;
        convData <= resultValue;
        busy <= 0;
      end
    end
  end
endmodule // adcctl_core_model

// ---- verification/adc_control_registers_tb.sv ----
`timescale 1ns/10ps
module adc_control_registers_tb;
  // ****************
  // Signals
  // ****************
  localparam int SETTLE = 50;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, pinPullHighAllow = 0;
  logic [31:0] pwdata = 0, v;
  logic lowVoltageDetectEn = 0, lowVoltageResetEn = 0;
  logic [11:0] resultValue = 0;
  wire [31:0] prdata;
  wire pready, pslverr, irq, convPowerDown, convReset, convStart;
  wire convClkTick, convDone, extChannelConnect, srcSupply, srcIntRef;
  wire refAmpOn, bandgapOn, refFromSupply, refFromExtPin;
  wire refFromBandgap, extRefPinConnect, refOutputEnable;
  wire [11:0] convData;
  wire [2:0] extChannelSel, refMultiplier;
  wire [1:0] srcScale;
  wire [7:0] pinAnalogMask, pinDigitalEn, pinPullHighEn;
  int fail_count = 0, checks_done = 0, cyc = 0, i, n;
  logic [31:0] expQ[$];

  adcctl_top dut_u (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .convPowerDown(convPowerDown), .convReset(convReset),
    .convStart(convStart), .convClkTick(convClkTick),
    .convDone(convDone), .convData(convData),
    .extChannelConnect(extChannelConnect), .extChannelSel(extChannelSel),
    .srcSupply(srcSupply), .srcIntRef(srcIntRef), .srcScale(srcScale),
    .refAmpOn(refAmpOn), .bandgapOn(bandgapOn),
    .refFromSupply(refFromSupply), .refFromExtPin(refFromExtPin),
    .refFromBandgap(refFromBandgap), .refMultiplier(refMultiplier),
    .extRefPinConnect(extRefPinConnect),
    .refOutputEnable(refOutputEnable),
    .lowVoltageDetectEn(lowVoltageDetectEn),
    .lowVoltageResetEn(lowVoltageResetEn),
    .pinPullHighAllow(pinPullHighAllow), .pinAnalogMask(pinAnalogMask),
    .pinDigitalEn(pinDigitalEn), .pinPullHighEn(pinPullHighEn)
  );
  adcctl_core_model core_u (
    .clk(clk), .convReset(convReset), .convStart(convStart),
    .convClkTick(convClkTick), .resultValue(resultValue),
    .convDone(convDone), .convData(convData)
  );

  always #5 clk = ~clk;

  // ****************
  // Tasks
  // ****************
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("mismatches=%0d checks=%0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    // Second edge lets the sequencer land before ports are looked at
    repeat (2) @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    xfer(0, a, 0);
  endtask
  task tick_wait;
    do @(posedge clk); while (convClkTick !== 1'b1);
  endtask

  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && expQ.size() > 0)
      chk(prdata, expQ.pop_front());
    // Unmapped or unaligned offsets must be refused
    if (psel && penable && pready)
      chk(pslverr, paddr > 8'h18 || paddr[1:0] != 2'h0);
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict;
    end
  end

  // ****************
  // Scenarios
  // ****************
  initial begin
    v = $urandom(32'hf22a);
    repeat (20) @(posedge clk);
    resetn <= 1;
    repeat (3) @(posedge clk);
    rd(8'h00, 0);
    rd(8'h08, 0);
    rd(8'h0c, 32'hff);
    rd(8'h1c, 0);
    wr(8'h04, 32'hff);
    rd(8'h04, 32'he7);
    for (i = 0; i < 8; i++) begin
      v = $urandom & 7;
      wr(8'h00, 32'h20 | v);
      wr(8'h04, i << 5);
      n = (i == 0 || i == 4);
      chk(extChannelConnect, n);
      chk(extChannelSel, v);
      chk(srcSupply, i >= 1 && i <= 3);
      chk(srcIntRef, i >= 5);
      chk(srcScale, n ? 0 : (i & 3) - 1);
    end
    for (i = 0; i < 8; i++) begin
      wr(8'h04, i);
      tick_wait;
      tick_wait;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (convClkTick !== 1'b1);
      chk(n, 1 << i);
    end
    for (i = 0; i < 16; i++) begin
      v = ($urandom & 32'hf0) | i;
      {lowVoltageDetectEn, lowVoltageResetEn} <= 2'($urandom);
      wr(8'h08, v);
      n = (i >= 10 && i <= 12);
      chk(refAmpOn, v[7]);
      chk(bandgapOn, v[6] | lowVoltageDetectEn | lowVoltageResetEn);
      chk(extRefPinConnect, v[5] & !n);
      chk(refOutputEnable, v[4]);
      chk(refFromBandgap, n);
      chk(refFromExtPin, i >= 1 && i <= 4);
      chk(refFromSupply, !n && !(i >= 1 && i <= 4));
      chk(refMultiplier, n ? i - 8 : (i >= 1 && i <= 4) ? i : 1);
    end
    v = $urandom;
    pinPullHighAllow <= v[15:8];
    wr(8'h0c, v[7:0]);
    chk(pinAnalogMask, v[7:0]);
    chk(pinDigitalEn, 8'(~v[7:0]));
    chk(pinPullHighEn, 8'(v[15:8] & ~v[7:0]));
    wr(8'h04, 3);
    wr(8'h18, 1);
    wr(8'h08, 32'h4a);
    repeat (SETTLE) @(posedge clk);
    for (i = 0; i < 2; i++) begin
      resultValue <= 12'($urandom);
      v = 32'h20 | (i << 4);
      wr(8'h00, v | 32'h80);
      chk(convReset, 1);
      rd(8'h00, v | 32'h80);
      wr(8'h00, v);
      rd(8'h00, v | 32'h40);
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
        @(posedge clk);
        n++;
      end
      chk(irq, 1);
      rd(8'h00, v);
      rd(8'h10, i ? resultValue : {resultValue, 4'h0});
      wr(8'h18, 0);
      chk(irq, 0);
      wr(8'h18, 1);
      chk(irq, 1);
      wr(8'h14, 1);
      chk(irq, 0);
      rd(8'h14, 0);
    end
    // Rewriting start mid-conversion aborts and holds reset
    wr(8'h00, 32'ha0);
    wr(8'h00, 32'h20);
    wr(8'h00, 32'ha0);
    chk(convReset, 1);
    rd(8'h00, 32'ha0);
    rd(8'h14, 0);
    wr(8'h00, 0);
    chk(convPowerDown, 1);
    wr(8'h00, 32'h80);
    rd(8'h00, 32'h80);
    wr(8'h00, 0);
    rd(8'h00, 0);
    rd(8'h10, {resultValue, 4'h0});
    give_verdict;
  end
endmodule // adc_control_registers_tb
